/* File: test/lhp_checker.sv */
// Purpose: pin-level checks between the host and device ends
// Assumes: all pins sampled on pclk, presetn async active low
// Notes: sees only interface signals, placed beside the interface
`timescale 1ns/1ns
module lhp_checker (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // straps and strobes
  input wire logic       bus_form_select_lo,
  input wire logic       bus_form_select_hi,
  input wire logic       strobe_style_select,
  input wire logic       cs_n,
  input wire logic       rd_ds_n,
  input wire logic       wr_rw_n,
  input wire logic       alt_address_strobe,
  input wire logic       hw_reset_n,
  input wire logic [4:0] register_addr_in,
  // data bus and interrupt
  input wire logic [7:0] shared_addr_data_bus,
  input wire logic       dev_data_oe,
  input wire logic       int_out,
  input wire logic       int_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // a read in either strobe style: direction line high in both
  wire logic rd_seen = !cs_n && !rd_ds_n && wr_rw_n && hw_reset_n;

  a_drive_only_read: assert property (
    dev_data_oe |-> $past(rd_seen))
    else $error("data bus driven outside a selected read");
  a_read_drives_bus: assert property (
    rd_seen && !bus_form_select_hi |=> dev_data_oe)
    else $error("selected read left the data bus undriven");
  a_serial_stays_off: assert property (
    bus_form_select_hi && $past(bus_form_select_hi) |-> !dev_data_oe)
    else $error("data bus driven in a non-parallel form");
  a_addr_low_muxed: assert property (
    !bus_form_select_hi && !bus_form_select_lo
      |-> register_addr_in == 5'h00)
    else $error("address pins not low in muxed form");
  a_ale_low_sep: assert property (
    !bus_form_select_hi && bus_form_select_lo |-> !alt_address_strobe)
    else $error("address strobe active in separate form");
  a_cs_frames_strobe: assert property (
    (!rd_ds_n || (!strobe_style_select && !wr_rw_n)) |-> !cs_n)
    else $error("strobe active without chip select");
  a_cs_strobe_width: assert property (
    $fell(cs_n) |-> !cs_n [*4])
    else $error("chip select shorter than the strobe time");
  a_ale_holds_addr: assert property (
    $rose(alt_address_strobe) |=> alt_address_strobe
      && $stable(shared_addr_data_bus) ##1 !alt_address_strobe
      && $stable(shared_addr_data_bus))
    else $error("address not held across the latch strobe");
  a_int_pulls_low: assert property (
    int_oe |-> !int_out)
    else $error("interrupt pin driven high");
endmodule // lhp_checker

/* File: test/lhp_tb.sv */
// Purpose: self-checking bench for both ends of the parallel port
// Assumes: device reached only through the host APB registers
// Notes: random data from a fixed seed; strap forms swept in loops
`timescale 1ns/1ns
module lhp_tb;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, r;
  logic [7:0]      cond_in, status_out, d, d8, st, exp_ctrl [29];
  logic [4:0]      a5;
  logic [29*8-1:0] ctrl_out;
  logic            e;
  int              mismatches, num_checks, cyc;

  lhp_if i_if ();
  lhp_host i_lhp_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(i_if));
  lhp_device #(.NUM_CTRL(29)) i_lhp_device (.pins(i_if), .pclk(pclk),
    .presetn(presetn), .cond_in(cond_in), .ctrl_out(ctrl_out),
    .status_out(status_out));
  lhp_checker i_lhp_checker (.pclk(pclk), .presetn(presetn),
    .bus_form_select_lo(i_if.bus_form_select_lo),
    .bus_form_select_hi(i_if.bus_form_select_hi),
    .strobe_style_select(i_if.strobe_style_select), .cs_n(i_if.cs_n),
    .rd_ds_n(i_if.rd_ds_n), .wr_rw_n(i_if.wr_rw_n),
    .alt_address_strobe(i_if.alt_address_strobe),
    .hw_reset_n(i_if.hw_reset_n), .register_addr_in(i_if.register_addr_in),
    .shared_addr_data_bus(i_if.shared_addr_data_bus),
    .dev_data_oe(i_if.dev_data_oe), .int_out(i_if.int_out),
    .int_oe(i_if.int_oe));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // a hung handshake ends here rather than running forever
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 32'h4e20)
    begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end

  // sticky status: set by a present condition or by any change
  function automatic logic [7:0] st_next(input logic [7:0] s, o, n);
    return s | n | (o ^ n);
  endfunction

  task automatic chk(input string n, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", n, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic w, input logic [4:0] a,
                     input logic [7:0] wd);
    apb(1'b1, lhp_pkg::APB_CMD, {15'h0000, w, 3'h0, a, wd});
  endtask

  task automatic wait_idle();
    do
      apb(1'b0, lhp_pkg::APB_STAT, 32'h0);
    while (r[lhp_pkg::STAT_BUSY_BIT] !== 1'b0);
    d = r[lhp_pkg::STAT_RDATA_LSB +: 8];
  endtask

  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [7:0] wd);
    cmd(w, a, wd);
    wait_idle();
  endtask

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, cond_in} = 55'h0;
    void'($urandom(32'hfb55));
    foreach (exp_ctrl[i])
      exp_ctrl[i] = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lhp_pkg::APB_MODE, 32'h0);
    chk("mode_reset", r, 32'(lhp_pkg::MODE_RESET));
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped", r, 32'h0);
    // both parallel forms in both strobe styles, with both ends of the control register range
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, lhp_pkg::APB_MODE, {29'h0, m[1], 1'b0, m[0]});
      for (int k = 0; k < 4; k++)
      begin
        a5 = (k == 0) ? 5'h00 : (k == 1) ? 5'h1c : 5'($urandom_range(28));
        d8 = 8'($urandom);
        xfer(1'b1, a5, d8);
        exp_ctrl[a5] = d8;
        xfer(1'b0, a5, 8'h00);
        chk("readback", 32'(d), 32'(d8));
      end
      for (int i = 0; i < 29; i++)
        chk("ctrl", 32'(ctrl_out[i*8 +: 8]), 32'(exp_ctrl[i]));
    end
    // serial and hardware forms must leave the registers alone
    for (int f = 2; f < 4; f++)
    begin
      apb(1'b1, lhp_pkg::APB_MODE, 32'(f));
      xfer(1'b1, 5'h05, ~exp_ctrl[5]);
      chk("no_parallel", 32'(ctrl_out[47:40]), 32'(exp_ctrl[5]));
      // nobody drives the bus, so the host reads the idle level
      xfer(1'b0, 5'h05, 8'h00);
      chk("no_parallel_rd", 32'(d), 32'h0);
    end
    apb(1'b1, lhp_pkg::APB_MODE, 32'h1);
    cmd(1'b1, 5'h07, 8'ha5);
    cmd(1'b1, 5'h07, 8'h5a);
    chk("busy_refuse", 32'(e), 32'h1);
    wait_idle();
    chk("first_kept", 32'(ctrl_out[63:56]), 32'ha5);
    xfer(1'b1, lhp_pkg::REG_INT_EN, 8'h0f);
    cond_in <= 8'h30;
    st = st_next(8'h00, 8'h00, 8'h30);
    repeat (4) @(posedge pclk);
    chk("int_masked", 32'(i_if.int_n), 32'h1);
    xfer(1'b0, lhp_pkg::REG_COND, 8'h00);
    chk("cond", 32'(d), 32'h30);
    cond_in <= 8'h01;
    st = st_next(st, 8'h30, 8'h01);
    repeat (4) @(posedge pclk);
    chk("status", 32'(status_out), 32'(st));
    chk("int_low", 32'(i_if.int_n), 32'h0);
    cond_in <= 8'h00;
    repeat (4) @(posedge pclk);
    xfer(1'b1, lhp_pkg::REG_STATUS, 8'hff);
    repeat (3) @(posedge pclk);
    chk("int_clear", 32'({i_if.int_n, status_out}), 32'h100);
    // a clear that meets a present condition must lose
    cond_in <= 8'h02;
    repeat (3) @(posedge pclk);
    xfer(1'b1, lhp_pkg::REG_STATUS, 8'hff);
    repeat (3) @(posedge pclk);
    chk("set_wins", 32'(status_out),
        32'(st_next(8'h00, 8'h02, 8'h02)));
    chk("int_set_wins", 32'(i_if.int_n), 32'h0);
    presetn <= 1'b0;
    cond_in <= 8'h00;
    repeat (3) @(posedge pclk);
    chk("hw_reset", 32'(|ctrl_out), 32'h0);
    presetn <= 1'b1;
    // both ends must come back usable after a mid-run reset
    apb(1'b0, lhp_pkg::APB_MODE, 32'h0);
    chk("mode_rst2", r, 32'(lhp_pkg::MODE_RESET));
    xfer(1'b0, 5'h07, 8'h00);
    chk("rd_after_rst", 32'(d), 32'(lhp_pkg::CTRL_RESET));
    end_sim();
  end
endmodule // lhp_tb

/* File: verilog/lhp_device.sv */
// Purpose: device end of the parallel host port with its register file
// Assumes: pins synchronous to pclk; one cycle of read latency
// Notes: writes commit when the write strobe ends
`timescale 1ns/1ns
module lhp_device #(
  parameter int NUM_CTRL = lhp_pkg::NUM_CTRL
) (
  // pins
  lhp_if.dev                  pins,
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // user side
  input  wire logic [7:0]     cond_in,
  output logic [NUM_CTRL*8-1:0] ctrl_out,
  output logic [7:0]          status_out
);
  logic [7:0] ctrl_q [NUM_CTRL];
  logic [7:0] ctrl_d [NUM_CTRL];
  logic [7:0] int_en_q;
  logic [7:0] int_en_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] cond_prev_q;
  logic [4:0] mux_addr_q;
  logic [4:0] mux_addr_d;
  logic [4:0] waddr_q;
  logic [4:0] waddr_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic       wr_act_q;
  logic       ale_q;
  logic [7:0] dout_q;
  logic [7:0] dout_d;
  logic       doe_q;
  logic       doe_d;
  logic       int_oe_q;
  logic       int_oe_d;
  logic       parallel;
  logic       muxed;
  logic       moto;
  logic       sel;
  logic       rd_act;
  logic       wr_act;
  logic       commit;
  logic [4:0] acc_addr;
  logic [7:0] rd_val;
  logic [1:0] form;

  // pin decode
  always_comb
  begin
    form     = {pins.bus_form_select_hi, pins.bus_form_select_lo};
    parallel = (form == lhp_pkg::FORM_MUXED) ||
               (form == lhp_pkg::FORM_SEPARATE);
    muxed    = (form == lhp_pkg::FORM_MUXED);
    moto     = pins.strobe_style_select;
    sel      = parallel && !pins.cs_n && pins.hw_reset_n;
    if (moto)
    begin
      rd_act = sel && !pins.rd_ds_n && pins.wr_rw_n;
      wr_act = sel && !pins.rd_ds_n && !pins.wr_rw_n;
    end
    else
    begin
      rd_act = sel && !pins.rd_ds_n;
      wr_act = sel && !pins.wr_rw_n && pins.rd_ds_n;
    end
    acc_addr = muxed ? mux_addr_q : pins.register_addr_in;
    commit   = wr_act_q && !wr_act;
  end

  // address latch and write capture
  always_comb
  begin
    mux_addr_d = mux_addr_q;
    waddr_d    = waddr_q;
    wdata_d    = wdata_q;
    // positive-going latch strobe demultiplexes the bus
    if (parallel && muxed && pins.alt_address_strobe && !ale_q)
    begin
      mux_addr_d = pins.shared_addr_data_bus[4:0];
    end
    // last sampled value before the strobe ends is the one written
    if (wr_act)
    begin
      waddr_d = acc_addr;
      wdata_d = pins.shared_addr_data_bus;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mux_addr_q <= 5'h00;
      waddr_q    <= 5'h00;
      wdata_q    <= 8'h00;
      wr_act_q   <= 1'b0;
      ale_q      <= 1'b0;
    end
    else
    begin
      mux_addr_q <= mux_addr_d;
      waddr_q    <= waddr_d;
      wdata_q    <= wdata_d;
      wr_act_q   <= wr_act;
      ale_q      <= pins.alt_address_strobe;
    end
  end

  // register file
  always_comb
  begin
    for (int i = 0; i < NUM_CTRL; i++)
    begin
      ctrl_d[i] = ctrl_q[i];
      if (!pins.hw_reset_n)
        ctrl_d[i] = lhp_pkg::CTRL_RESET;
      else if (commit && (waddr_q == 5'(i)))
        ctrl_d[i] = wdata_q;
    end
    int_en_d = int_en_q;
    if (!pins.hw_reset_n)
      int_en_d = lhp_pkg::CTRL_RESET;
    else if (commit && (waddr_q == lhp_pkg::REG_INT_EN))
      int_en_d = wdata_q;
    // writing ones clears; a condition present that cycle keeps its bit
    status_d = status_q;
    if (!pins.hw_reset_n)
      status_d = 8'h00;
    else
    begin
      if (commit && (waddr_q == lhp_pkg::REG_STATUS))
        status_d = status_d & ~wdata_q;
      status_d = status_d | cond_in | (cond_in ^ cond_prev_q);
    end
    int_oe_d = |(status_d & int_en_d);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CTRL; i++)
        ctrl_q[i] <= lhp_pkg::CTRL_RESET;
      int_en_q    <= lhp_pkg::CTRL_RESET;
      status_q    <= 8'h00;
      cond_prev_q <= 8'h00;
      int_oe_q    <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_CTRL; i++)
        ctrl_q[i] <= ctrl_d[i];
      int_en_q    <= int_en_d;
      status_q    <= status_d;
      cond_prev_q <= cond_in;
      int_oe_q    <= int_oe_d;
    end
  end

  // read path
  always_comb
  begin
    rd_val = 8'h00;
    if (acc_addr < 5'(NUM_CTRL))
      rd_val = ctrl_q[acc_addr];
    else if (acc_addr == lhp_pkg::REG_COND)
      rd_val = cond_in;
    else if (acc_addr == lhp_pkg::REG_INT_EN)
      rd_val = int_en_q;
    else if (acc_addr == lhp_pkg::REG_STATUS)
      rd_val = status_q;
    doe_d  = rd_act;
    dout_d = rd_act ? rd_val : 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dout_q <= 8'h00;
      doe_q  <= 1'b0;
    end
    else
    begin
      dout_q <= dout_d;
      doe_q  <= doe_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CTRL; g++)
    begin : g_ctrl
      assign ctrl_out[g*8 +: 8] = ctrl_q[g];
    end
  endgenerate

  assign status_out        = status_q;
  assign pins.dev_data_out = dout_q;
  assign pins.dev_data_oe  = doe_q;
  // open drain: only ever pulls low
  assign pins.int_out      = 1'b0;
  assign pins.int_oe       = int_oe_q;
endmodule // lhp_device

/* File: verilog/lhp_host.sv */
// Purpose: host controller driving the parallel port from APB
// Assumes: APB slave answers with one wait state
// Notes: one transfer at a time; command while busy is refused
`timescale 1ns/1ns
module lhp_host (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  lhp_if.host              pins
);
  typedef enum logic [2:0] {
    LHP_IDLE, LHP_ALE_HI, LHP_ALE_LO, LHP_STROBE, LHP_RECOVER
  } lhp_state_e;

  lhp_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] mode_q, mode_d;
  logic       wr_q, wr_d;
  logic [4:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] rdata_q, rdata_d;
  logic       cs_n_q, cs_n_d, rd_q, rd_d, wrs_q, wrs_d, ale_q, ale_d;
  logic [4:0] pa_q, pa_d;
  logic [7:0] pd_q, pd_d;
  logic       poe_q, poe_d;
  logic [31:0] prdata_d;
  logic       pready_d, pslverr_d, acc, go, moto, muxed;

  always_comb
  begin
    acc   = psel && penable && pready;
    moto  = mode_q[lhp_pkg::MODE_STYLE_BIT];
    muxed = (mode_q[1:0] == lhp_pkg::FORM_MUXED);
    go    = acc && pwrite && (paddr == lhp_pkg::APB_CMD) &&
            (st_q == LHP_IDLE);
    pready_d  = psel && penable && !pready;
    pslverr_d = pready_d && pwrite && (paddr == lhp_pkg::APB_CMD) &&
                (st_q != LHP_IDLE);
    prdata_d  = 32'h0000_0000;
    if (paddr == lhp_pkg::APB_STAT)
    begin
      prdata_d[lhp_pkg::STAT_BUSY_BIT] = (st_q != LHP_IDLE);
      prdata_d[lhp_pkg::STAT_RDATA_LSB +: 8] = rdata_q;
    end
    else if (paddr == lhp_pkg::APB_MODE)
      prdata_d[2:0] = mode_q;
    mode_d = mode_q;
    if (acc && pwrite && (paddr == lhp_pkg::APB_MODE) && st_q == LHP_IDLE)
      mode_d = pwdata[2:0];
    st_d = st_q; cnt_d = cnt_q; wr_d = wr_q; addr_d = addr_q;
    wdata_d = wdata_q; rdata_d = rdata_q;
    cs_n_d = 1'b1; rd_d = 1'b0; wrs_d = 1'b0; ale_d = 1'b0;
    pa_d = 5'h00; pd_d = 8'h00; poe_d = 1'b0;
    unique case (st_q)
      LHP_IDLE:
      begin
        if (go)
        begin
          wr_d    = pwdata[lhp_pkg::CMD_WR_BIT];
          addr_d  = pwdata[lhp_pkg::CMD_ADDR_LSB +: 5];
          wdata_d = pwdata[7:0];
          cnt_d   = 4'h0;
          st_d    = muxed ? LHP_ALE_HI : LHP_STROBE;
        end
      end
      LHP_ALE_HI:
      begin
        ale_d = 1'b1;
        pd_d = {3'h0, addr_q}; poe_d = 1'b1;
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'(lhp_pkg::ALE_CYC - 1))
        begin
          cnt_d = 4'h0; st_d = LHP_ALE_LO;
        end
      end
      LHP_ALE_LO:
      begin
        pd_d = {3'h0, addr_q}; poe_d = 1'b1;
        st_d = LHP_STROBE;
      end
      LHP_STROBE:
      begin
        cs_n_d = 1'b0;
        rd_d  = !wr_q || moto;
        wrs_d = wr_q;
        poe_d = wr_q;
        pd_d  = wr_q ? wdata_q : 8'h00;
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'(lhp_pkg::STROBE_CYC - 1))
        begin
          if (!wr_q)
            rdata_d = pins.shared_addr_data_bus;
          cnt_d = 4'h0; st_d = LHP_RECOVER;
        end
      end
      LHP_RECOVER:
      begin
        // hold write data past the strobe's end
        poe_d = wr_q; pd_d = wr_q ? wdata_q : 8'h00;
        st_d = LHP_IDLE;
      end
    endcase
    if (!muxed)
      pa_d = (st_q == LHP_IDLE) ? 5'h00 : addr_q;
    if (!muxed || !(st_d == LHP_ALE_HI || st_q == LHP_ALE_HI))
      ale_d = ale_d && muxed;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= LHP_IDLE; cnt_q <= 4'h0; mode_q <= lhp_pkg::MODE_RESET;
      wr_q <= 1'b0; addr_q <= 5'h00; wdata_q <= 8'h00; rdata_q <= 8'h00;
      cs_n_q <= 1'b1; rd_q <= 1'b0; wrs_q <= 1'b0; ale_q <= 1'b0;
      pa_q <= 5'h00; pd_q <= 8'h00; poe_q <= 1'b0;
      prdata <= 32'h0000_0000; pready <= 1'b0; pslverr <= 1'b0;
    end
    else
    begin
      st_q <= st_d; cnt_q <= cnt_d; mode_q <= mode_d;
      wr_q <= wr_d; addr_q <= addr_d; wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      cs_n_q <= cs_n_d; rd_q <= rd_d; wrs_q <= wrs_d; ale_q <= ale_d;
      pa_q <= pa_d; pd_q <= pd_d; poe_q <= poe_d;
      prdata <= prdata_d; pready <= pready_d; pslverr <= pslverr_d;
    end
  end

  assign pins.bus_form_select_lo  = mode_q[lhp_pkg::MODE_FORM_LSB];
  assign pins.bus_form_select_hi  = mode_q[lhp_pkg::MODE_FORM_LSB + 1];
  assign pins.strobe_style_select = moto;
  assign pins.cs_n               = cs_n_q;
  // read/write style: read low; strobe style: data strobe low
  assign pins.rd_ds_n            = !rd_q;
  // read/write style: write low; strobe style: direction, low for write
  assign pins.wr_rw_n            = moto ? !(wrs_q) : !wrs_q;
  assign pins.alt_address_strobe = ale_q;
  assign pins.hw_reset_n         = presetn;
  assign pins.register_addr_in   = pa_q;
  assign pins.host_data_out      = pd_q;
  assign pins.host_data_oe       = poe_q;
endmodule // lhp_host

/* File: verilog/lhp_if.sv */
// Purpose: pin bundle between host controller and device port
// Assumes: both ends on pclk; shared wires resolved here from enables
// Notes: undriven data bus reads as zero, idle interrupt line reads one
`timescale 1ns/1ns
interface lhp_if;
  // straps
  logic       bus_form_select_lo;
  logic       bus_form_select_hi;
  logic       strobe_style_select;
  // strobes
  logic       cs_n;
  logic       rd_ds_n;
  logic       wr_rw_n;
  logic       alt_address_strobe;
  logic       hw_reset_n;
  logic [4:0] register_addr_in;
  // data bus, split per driver
  logic [7:0] host_data_out;
  logic       host_data_oe;
  logic [7:0] dev_data_out;
  logic       dev_data_oe;
  logic [7:0] shared_addr_data_bus;
  // open-drain interrupt
  logic       int_out;
  logic       int_oe;
  logic       int_n;

  assign shared_addr_data_bus = dev_data_oe ? dev_data_out :
                                host_data_oe ? host_data_out : 8'h00;
  assign int_n = int_oe ? int_out : 1'b1;

  modport dev (
    input  bus_form_select_lo, bus_form_select_hi, strobe_style_select,
    input  cs_n, rd_ds_n, wr_rw_n, alt_address_strobe, hw_reset_n,
    input  register_addr_in, shared_addr_data_bus,
    output dev_data_out, dev_data_oe, int_out, int_oe
  );
  modport host (
    output bus_form_select_lo, bus_form_select_hi, strobe_style_select,
    output cs_n, rd_ds_n, wr_rw_n, alt_address_strobe, hw_reset_n,
    output register_addr_in, host_data_out, host_data_oe,
    input  shared_addr_data_bus, int_n
  );
endinterface

/* File: verilog/lhp_pkg.sv */
// Purpose: shared constants for the parallel host port, both ends
// Assumes: one 100 MHz clock pclk, pins sampled synchronously
// Notes: device map and host APB map live here
// Summary of operation
// - separate form uses address pins; muxed holds them low
// - muxed form latches address on strobe rise
// - separate form keeps address latch strobe low
// - strobes only count while chip select low
// - data pins plain bus, or shared address/data
// - hardware reset clears every control bit
// - open-drain interrupt low on enabled status
// - host holds unused inputs low
// - selects decode muxed, separate, serial, hardware
// - style select picks strobe pin meanings
// - read strobe or data strobe starts read
// - write strobe or direction low starts write
package lhp_pkg;
  localparam int          ADDR_W         = 5;
  localparam int          DATA_W         = 8;
  localparam logic [1:0]  FORM_MUXED     = 2'b00;
  localparam logic [1:0]  FORM_SEPARATE  = 2'b01;
  localparam logic [1:0]  FORM_SERIAL    = 2'b10;
  localparam logic [1:0]  FORM_HARDWARE  = 2'b11;
  localparam int          NUM_CTRL       = 29;
  localparam logic [4:0]  REG_COND       = 5'h1d;
  localparam logic [4:0]  REG_INT_EN     = 5'h1e;
  localparam logic [4:0]  REG_STATUS     = 5'h1f;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [11:0] APB_CMD        = 12'h000;
  localparam logic [11:0] APB_STAT       = 12'h004;
  localparam logic [11:0] APB_MODE       = 12'h008;
  localparam int          CMD_ADDR_LSB   = 8;
  localparam int          CMD_WR_BIT     = 16;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_RDATA_LSB = 8;
  localparam int          MODE_FORM_LSB  = 0;
  localparam int          MODE_STYLE_BIT = 2;
  localparam logic [2:0]  MODE_RESET     = 3'h1;
  localparam int          CLK_NS         = 10;
  localparam int          STROBE_NS      = 40;
  localparam int          STROBE_CYC     = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          ALE_NS         = 20;
  localparam int          ALE_CYC        = (ALE_NS + CLK_NS - 1) / CLK_NS;
endpackage
